// >>> dra_pkg.sv
// Summary of operation
// - rotation select 00/01/10/11 means 0/90/180/270
// - rotation runs counter-clockwise in quarter turns
// - rotation works at 1,2,4,8,16 bpp
// - at 90/270 width and height swap
// - start address is 17-bit dword, three registers
// - line offset is dwords per stored line
// - right-justified starts at virtual minus image width
package dra_pkg;

  // ==========================================
  // register offsets
  localparam logic [7:0] EFFECTS_CONTROL_OFS = 8'h71;
  localparam logic [7:0] MAIN_START_ADDR_LOW_OFS = 8'h74;
  localparam logic [7:0] MAIN_START_ADDR_MID_OFS = 8'h75;
  localparam logic [7:0] MAIN_START_ADDR_HIGH_OFS = 8'h76;
  localparam logic [7:0] MAIN_LINE_OFFSET_LOW_OFS = 8'h78;
  localparam logic [7:0] MAIN_LINE_OFFSET_HIGH_OFS = 8'h79;
  localparam logic [7:0] DISPLAY_MODE_OFS = 8'hA8;
  localparam logic [7:0] PANEL_WIDTH_LOW_OFS = 8'hAC;
  localparam logic [7:0] PANEL_WIDTH_HIGH_OFS = 8'hAD;
  localparam logic [7:0] PANEL_HEIGHT_LOW_OFS = 8'hAE;
  localparam logic [7:0] PANEL_HEIGHT_HIGH_OFS = 8'hAF;
  localparam logic [7:0] FETCH_CONTROL_OFS = 8'hB0;
  localparam logic [7:0] FETCH_STATUS_OFS = 8'hB1;

  // ==========================================
  // field positions and widths
  localparam int ROT_SEL_LSB = 0;
  localparam int ADDR_W = 17;
  localparam int OFS_W = 10;
  localparam int DIM_W = 10;
  localparam int RUN_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int ROT_STAT_LSB = 2;
  localparam int DWORD_BITS_LOG2 = 5;

  // ==========================================
  // reset values
  localparam logic [7:0] EFFECTS_RST = 8'h00;
  localparam logic [16:0] START_RST = 17'h00000;
  localparam logic [9:0] OFS_RST = 10'h000;
  localparam logic [9:0] DIM_RST = 10'h000;
  localparam logic [2:0] BPP_RST = 3'h0;

  // ==========================================
  // types
  typedef enum logic [1:0] {
    DRA_ROT_0 = 2'h0,
    DRA_ROT_90 = 2'h1,
    DRA_ROT_180 = 2'h2,
    DRA_ROT_270 = 2'h3
  } dra_rot_t;

  typedef enum logic [2:0] {
    DRA_BPP_1 = 3'h0,
    DRA_BPP_2 = 3'h1,
    DRA_BPP_4 = 3'h2,
    DRA_BPP_8 = 3'h3,
    DRA_BPP_16 = 3'h4
  } dra_bpp_t;

  typedef enum logic [1:0] {
    DRA_ST_IDLE = 2'h0,
    DRA_ST_RUN = 2'h1,
    DRA_ST_END = 2'h2
  } dra_state_t;

  typedef struct packed {
    logic eof;
    logic sol;
    logic [16:0] addr;
  } dra_fetch_t;

endpackage

// >>> dra_buf2.sv
`timescale 1ns/1ps
module dra_buf2 #(
  parameter int W = 19
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  // ==========================================
  // two-entry store, head is entry 0
  logic [W-1:0] mem_q [2];
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[0];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      if (pop) begin
        mem_q[0] <= mem_q[1];
      end
      if (push) begin
        if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
          mem_q[0] <= in_data_i;
        end else begin
          mem_q[cnt_q[0] && !pop] <= in_data_i;
        end
      end
    end
  end

endmodule

// >>> dra_orient_dec.sv
`timescale 1ns/1ps
module dra_orient_dec (
  input wire logic [1:0] rot_i,
  input wire logic [2:0] bpp_i,
  input wire logic [9:0] line_off_i,
  input wire logic [9:0] panel_w_i,
  input wire logic [9:0] panel_h_i,
  output logic [16:0] in_step_o,
  output logic [16:0] out_step_o,
  output logic [9:0] in_len_o,
  output logic [9:0] out_len_o
);

  // dwords needed for n pixels, rounded up to a whole dword
  function automatic logic [9:0] dwords(input logic [9:0] n,
                                        input logic [2:0] bpp);
    logic [2:0] sh;
    logic [10:0] sum;
    sh = 3'(dra_pkg::DWORD_BITS_LOG2) - bpp;
    sum = {1'b0, n} + ((11'h001 << sh) - 11'h001);
    return 10'(sum >> sh);
  endfunction

  logic [16:0] off;
  logic [16:0] one;

  assign off = {7'h00, line_off_i};
  assign one = 17'h00001;

  // ==========================================
  // steps as two's complement, wrap in 17 bits
  always_comb begin
    in_step_o = one;
    out_step_o = off;
    in_len_o = dwords(panel_w_i, bpp_i);
    out_len_o = panel_h_i;
    case (dra_pkg::dra_rot_t'(rot_i))
      dra_pkg::DRA_ROT_0: begin
        in_step_o = one;
        out_step_o = off;
      end
      dra_pkg::DRA_ROT_90: begin
        // columns walked right to left, lines downwards
        in_step_o = off;
        out_step_o = 17'(-one);
        in_len_o = panel_w_i;
        out_len_o = dwords(panel_h_i, bpp_i);
      end
      dra_pkg::DRA_ROT_180: begin
        in_step_o = 17'(-one);
        out_step_o = 17'(-off);
      end
      dra_pkg::DRA_ROT_270: begin
        in_step_o = 17'(-off);
        out_step_o = one;
        in_len_o = panel_w_i;
        out_len_o = dwords(panel_h_i, bpp_i);
      end
      default: begin
        in_step_o = one;
        out_step_o = off;
      end
    endcase
  end

endmodule

// >>> dra_top.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
module dra_top (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic fetch_valid_o,
  input wire logic fetch_ready_i,
  output dra_pkg::dra_fetch_t fetch_o
);

  // ==========================================
  // register storage
  logic [7:0] effects_q;
  logic [16:0] start_q;
  logic [9:0] line_off_q;
  logic [2:0] bpp_q;
  logic [9:0] panel_w_q;
  logic [9:0] panel_h_q;
  logic run_q;
  logic [7:0] rdata_q;

  // ==========================================
  // walker state
  dra_pkg::dra_state_t state_q;
  logic [16:0] addr_q;
  logic [16:0] base_q;
  logic [9:0] in_cnt_q;
  logic [9:0] out_cnt_q;
  logic [16:0] in_step_q;
  logic [16:0] out_step_q;
  logic [9:0] in_len_q;
  logic [9:0] out_len_q;
  logic [1:0] frame_rot_q;

  logic [16:0] dec_in_step;
  logic [16:0] dec_out_step;
  logic [9:0] dec_in_len;
  logic [9:0] dec_out_len;

  logic buf_in_ready;
  logic push;
  logic last_in;
  logic last_out;
  logic can_start;
  dra_pkg::dra_fetch_t word;
  logic start_frame;
  logic in_run;
  logic word_last;
  logic frame_done;
  logic busy;

  // ==========================================
  // write address decode, used by the effects, display mode and fetch control registers
  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr_i && (reg_addr_i == a);
  endfunction

  // ==========================================
  // register writes
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      effects_q <= dra_pkg::EFFECTS_RST;
    end else if (wr_hit(dra_pkg::EFFECTS_CONTROL_OFS)) begin
      effects_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_q <= dra_pkg::START_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        dra_pkg::MAIN_START_ADDR_LOW_OFS: begin
          start_q[7:0] <= reg_wdata_i;
        end
        dra_pkg::MAIN_START_ADDR_MID_OFS: begin
          start_q[15:8] <= reg_wdata_i;
        end
        dra_pkg::MAIN_START_ADDR_HIGH_OFS: begin
          start_q[16] <= reg_wdata_i[0];
        end
        default: begin
          start_q <= start_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_off_q <= dra_pkg::OFS_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        dra_pkg::MAIN_LINE_OFFSET_LOW_OFS: begin
          line_off_q[7:0] <= reg_wdata_i;
        end
        dra_pkg::MAIN_LINE_OFFSET_HIGH_OFS: begin
          line_off_q[9:8] <= reg_wdata_i[1:0];
        end
        default: begin
          line_off_q <= line_off_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bpp_q <= dra_pkg::BPP_RST;
    end else if (wr_hit(dra_pkg::DISPLAY_MODE_OFS)) begin
      // depths above 16 bpp fall back to 16 bpp
      if (reg_wdata_i[2:0] > 3'(dra_pkg::DRA_BPP_16)) begin
        bpp_q <= 3'(dra_pkg::DRA_BPP_16);
      end else begin
        bpp_q <= reg_wdata_i[2:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      panel_w_q <= dra_pkg::DIM_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        dra_pkg::PANEL_WIDTH_LOW_OFS: begin
          panel_w_q[7:0] <= reg_wdata_i;
        end
        dra_pkg::PANEL_WIDTH_HIGH_OFS: begin
          panel_w_q[9:8] <= reg_wdata_i[1:0];
        end
        default: begin
          panel_w_q <= panel_w_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      panel_h_q <= dra_pkg::DIM_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        dra_pkg::PANEL_HEIGHT_LOW_OFS: begin
          panel_h_q[7:0] <= reg_wdata_i;
        end
        dra_pkg::PANEL_HEIGHT_HIGH_OFS: begin
          panel_h_q[9:8] <= reg_wdata_i[1:0];
        end
        default: begin
          panel_h_q <= panel_h_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_q <= 1'b0;
    end else if (wr_hit(dra_pkg::FETCH_CONTROL_OFS)) begin
      run_q <= reg_wdata_i[dra_pkg::RUN_BIT];
    end
  end

  // ==========================================
  // register reads, data valid one cycle after strobe
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      dra_pkg::EFFECTS_CONTROL_OFS: v = effects_q;
      dra_pkg::MAIN_START_ADDR_LOW_OFS: v = start_q[7:0];
      dra_pkg::MAIN_START_ADDR_MID_OFS: v = start_q[15:8];
      dra_pkg::MAIN_START_ADDR_HIGH_OFS: v = {7'h00, start_q[16]};
      dra_pkg::MAIN_LINE_OFFSET_LOW_OFS: v = line_off_q[7:0];
      dra_pkg::MAIN_LINE_OFFSET_HIGH_OFS: v = {6'h00, line_off_q[9:8]};
      dra_pkg::DISPLAY_MODE_OFS: v = {5'h00, bpp_q};
      dra_pkg::PANEL_WIDTH_LOW_OFS: v = panel_w_q[7:0];
      dra_pkg::PANEL_WIDTH_HIGH_OFS: v = {6'h00, panel_w_q[9:8]};
      dra_pkg::PANEL_HEIGHT_LOW_OFS: v = panel_h_q[7:0];
      dra_pkg::PANEL_HEIGHT_HIGH_OFS: v = {6'h00, panel_h_q[9:8]};
      dra_pkg::FETCH_CONTROL_OFS: v = {7'h00, run_q};
      dra_pkg::FETCH_STATUS_OFS: begin
        v[dra_pkg::BUSY_BIT] = busy;
        v[dra_pkg::ROT_STAT_LSB +: 2] = frame_rot_q;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux(reg_addr_i);
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ==========================================
  // orientation decode
  dra_orient_dec u_dec (
    .rot_i(effects_q[dra_pkg::ROT_SEL_LSB +: 2]),
    .bpp_i(bpp_q),
    .line_off_i(line_off_q),
    .panel_w_i(panel_w_q),
    .panel_h_i(panel_h_q),
    .in_step_o(dec_in_step),
    .out_step_o(dec_out_step),
    .in_len_o(dec_in_len),
    .out_len_o(dec_out_len)
  );

  // ==========================================
  // scan walker
  assign last_in = (in_cnt_q == in_len_q - 10'h001);
  assign last_out = (out_cnt_q == out_len_q - 10'h001);
  assign push = in_run && buf_in_ready;
  assign can_start = run_q && (dec_in_len != 10'h000) &&
                     (dec_out_len != 10'h000);

  // ==========================================
  // frame start and end decode
  assign in_run = (state_q == dra_pkg::DRA_ST_RUN);
  assign start_frame = (state_q == dra_pkg::DRA_ST_IDLE) && can_start;
  assign word_last = last_in && last_out;
  assign frame_done = push && word_last;
  assign busy = (state_q != dra_pkg::DRA_ST_IDLE);

  always_comb begin
    word.addr = addr_q;
    word.sol = (in_cnt_q == 10'h000);
    word.eof = word_last;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= dra_pkg::DRA_ST_IDLE;
    end else begin
      case (state_q)
        dra_pkg::DRA_ST_IDLE: begin
          if (can_start) begin
            state_q <= dra_pkg::DRA_ST_RUN;
          end
        end
        dra_pkg::DRA_ST_RUN: begin
          if (frame_done) begin
            state_q <= dra_pkg::DRA_ST_END;
          end
        end
        dra_pkg::DRA_ST_END: begin
          state_q <= dra_pkg::DRA_ST_IDLE;
        end
        default: begin
          state_q <= dra_pkg::DRA_ST_IDLE;
        end
      endcase
    end
  end

  // frame settings frozen at frame start
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_step_q <= 17'h00000;
      out_step_q <= 17'h00000;
      in_len_q <= 10'h000;
      out_len_q <= 10'h000;
    end else if (start_frame) begin
      in_step_q <= dec_in_step;
      out_step_q <= dec_out_step;
      in_len_q <= dec_in_len;
      out_len_q <= dec_out_len;
    end
  end

  // rotation of the frame in flight, shown in the status register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_rot_q <= 2'h0;
    end else if (start_frame) begin
      frame_rot_q <= effects_q[dra_pkg::ROT_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_q <= 17'h00000;
    end else if (start_frame) begin
      addr_q <= start_q;
    end else if (push) begin
      if (last_in) begin
        addr_q <= base_q + out_step_q;
      end else begin
        addr_q <= addr_q + in_step_q;
      end
    end
  end

  // line base steps by out_step_q: the whole line offset, padding included, at 0/180, one dword at 90/270
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      base_q <= 17'h00000;
    end else if (start_frame) begin
      base_q <= start_q;
    end else if (push && last_in) begin
      base_q <= base_q + out_step_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_cnt_q <= 10'h000;
      out_cnt_q <= 10'h000;
    end else if (state_q == dra_pkg::DRA_ST_IDLE) begin
      in_cnt_q <= 10'h000;
      out_cnt_q <= 10'h000;
    end else if (push) begin
      if (last_in) begin
        in_cnt_q <= 10'h000;
        out_cnt_q <= out_cnt_q + 10'h001;
      end else begin
        in_cnt_q <= in_cnt_q + 10'h001;
      end
    end
  end

  // ==========================================
  // output buffer, stalls the walker
  dra_buf2 #(
    .W($bits(dra_pkg::dra_fetch_t))
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(in_run),
    .in_ready_o(buf_in_ready),
    .in_data_i(word),
    .out_valid_o(fetch_valid_o),
    .out_ready_i(fetch_ready_i),
    .out_data_o(fetch_o)
  );

endmodule

// >>> dra_asserts.sv
`timescale 1ns/1ps
module dra_asserts (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic fetch_valid_o,
  input wire logic fetch_ready_i,
  input wire dra_pkg::dra_fetch_t fetch_o
);
  // ==========================================
  // register readback and fetch stream checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic new_frame_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      new_frame_q <= 1'b1;
    end else if (fetch_valid_o && fetch_ready_i) begin
      new_frame_q <= fetch_o.eof;
    end
  end
  sequence wr_rd(a);
    reg_wr_i && reg_addr_i == a ##1 reg_rd_i && reg_addr_i == a;
  endsequence
  chk_rot_echo: assert property (
    wr_rd(8'h71) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("rotation select readback wrong");
  chk_start_low: assert property (
    wr_rd(8'h74) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("start address low readback wrong");
  chk_start_top: assert property (
    wr_rd(8'h76) |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h01))
    else $error("start address bit 16 readback wrong");
  chk_offset_low: assert property (
    wr_rd(8'h78) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("line offset low readback wrong");
  chk_offset_top: assert property (
    wr_rd(8'h79) |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h03))
    else $error("line offset high readback wrong");
  chk_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read");
  chk_fetch_hold: assert property (
    fetch_valid_o && !fetch_ready_i |=> fetch_valid_o && $stable(fetch_o))
    else $error("fetch word changed while stalled");
  chk_frame_sol: assert property (
    fetch_valid_o && new_frame_q |-> fetch_o.sol)
    else $error("first word of frame lacks line start");
endmodule

bind dra_top dra_asserts chk (.sys_clk_i, .rstn_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fetch_valid_o,
  .fetch_ready_i, .fetch_o);

// >>> dra_sink.sv
`timescale 1ns/1ps
module dra_sink (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire logic fetch_valid_i,
  input wire dra_pkg::dra_fetch_t fetch_i,
  output logic fetch_ready_o,
  output logic take_o,
  output dra_pkg::dra_fetch_t word_o
);
  // ==========================================
  // refresh consumer, stalls at random when slow
  logic [7:0] lfsr_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lfsr_q <= 8'h5A;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end
  assign fetch_ready_o = rstn_i && (!slow_i || lfsr_q[0]);
  assign take_o = fetch_valid_i && fetch_ready_o;
  assign word_o = fetch_i;
endmodule

// >>> dra_top_tb.sv
`timescale 1ns/1ps
module dra_top_tb;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic fetch_valid_o;
  logic fetch_ready_i;
  logic slow = 1'b0;
  logic take;
  dra_pkg::dra_fetch_t fetch_o;
  dra_pkg::dra_fetch_t word;
  dra_pkg::dra_fetch_t got[$];
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int r, b, u, bpp, w, h, il, ol, off, ba, st, n;
  logic [31:0] seed = 32'd31258;
  logic [7:0] v;
  logic [7:0] cfg[24];
  logic [7:0] ofs[10] = '{8'h71, 8'h74, 8'h75, 8'h76, 8'h78, 8'h79, 8'hAC,
    8'hAD, 8'hAE, 8'hAF};
  logic [7:0] msk[10] = '{8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'h03, 8'hFF,
    8'h03, 8'hFF, 8'h03};

  dra_top dut (.sys_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .fetch_valid_o, .fetch_ready_i, .fetch_o);
  dra_sink sink (.sys_clk_i, .rstn_i, .slow_i(slow),
    .fetch_valid_i(fetch_valid_o), .fetch_i(fetch_o),
    .fetch_ready_o(fetch_ready_i), .take_o(take), .word_o(word));

  always #2 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) begin
    if (take === 1'b1) got.push_back(word);
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [16:0] exp_addr(int k);
    int i = k % il;
    int o = k / il;
    case (r)
      0: return 17'(st + o * off + i);
      1: return 17'(st - o + i * off);
      2: return 17'(st - o * off - i);
      default: return 17'(st + o - i * off);
    endcase
  endfunction
  task automatic check(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic wr, rd, input logic [7:0] a, d);
    @(posedge sys_clk_i);
    reg_wr_i <= wr;
    reg_rd_i <= rd;
    reg_addr_i <= a;
    reg_wdata_i <= d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1 d = reg_rdata_o;
  endtask
  task report_and_stop();
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    foreach (ofs[j]) begin
      rd(ofs[j], v);
      check("reset value", v, 8'h00);
    end
    foreach (ofs[j]) begin
      cfg[0] = 8'(rnd());
      bus(1'b1, 1'b0, ofs[j], cfg[0]);
      rd(ofs[j], v);
      check("readback", v, cfg[0] & msk[j]);
    end
    bus(1'b1, 1'b0, 8'h77, 8'hA5);
    rd(8'h77, v);
    check("unmapped", v, 8'h00);
    bus(1'b1, 1'b0, 8'hA8, 8'h07);
    rd(8'hA8, v);
    check("depth clamp", v, 8'h04);
    for (int it = 0; it < 12; it++) begin
      r = it % 4;
      b = it % 5;
      u = 32 >> b;
      bpp = 1 << b;
      slow <= it[0];
      if (r % 2 == 0) begin
        w = u * (1 + rnd() % 3);
        h = 1 + rnd() % 4;
        il = w / u;
        ol = h;
      end else begin
        h = u * (1 + rnd() % 3);
        w = 1 + rnd() % 4;
        il = w;
        ol = h / u;
      end
      off = (r % 2 == 0 ? w / u : h / u) + rnd() % 2;
      ba = (it == 0) ? 32'h7FFF8 : 4 * (rnd() % 4096);
      // right-justified image inside a padded line
      if (r == 1 || r == 2) ba += off * 4 - (r == 1 ? h : w) * bpp / 8;
      case (r)
        0: st = ba / 4;
        1: st = (ba + h * bpp / 8 + ((4 - h * bpp / 8) & 3)) / 4 - 1;
        2: st = (ba + off * 4 * (h - 1) + w * bpp / 8
              + ((4 - w * bpp / 8) & 3)) / 4 - 1;
        default: st = (ba + (w - 1) * off * 4) / 4;
      endcase
      n = il * ol;
      cfg = '{8'hA8, 8'(b), 8'hAC, 8'(w), 8'hAD, 8'(w >> 8), 8'hAE, 8'(h),
        8'hAF, 8'(h >> 8), 8'h71, 8'(r), 8'h74, 8'(st), 8'h75, 8'(st >> 8),
        8'h76, 8'(st >> 16), 8'h78, 8'(off), 8'h79, 8'(off >> 8), 8'hB0,
        8'h01};
      for (int j = 0; j < 24; j += 2) bus(1'b1, 1'b0, cfg[j], cfg[j + 1]);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      for (int k = 0; k < 5000 && got.size() < n; k++) @(posedge sys_clk_i);
      bus(1'b1, 1'b0, 8'hB0, 8'h00);
      v = 8'h01;
      for (int k = 0; k < 2000 && v[0] !== 1'b0; k++) rd(8'hB1, v);
      check("latched rotation", v[3:2], r[1:0]);
      for (int k = 0; k < 500 && fetch_valid_o !== 1'b0; k++) begin
        @(posedge sys_clk_i);
      end
      #1 check("frame words", got.size() % n, 0);
      check("frame seen", got.size() >= n, 1);
      foreach (got[k]) begin
        check("address", got[k].addr, exp_addr(k % n));
        check("line start", got[k].sol, k % il == 0);
        check("frame end", got[k].eof, k % n == n - 1);
      end
      got.delete();
    end
    report_and_stop();
  end
endmodule
